/* src/pll_clock_select_map.vh */
// register offsets, field positions, reset values and timing constants of the clock select block
`ifndef PLL_CLOCK_SELECT_MAP_VH
`define PLL_CLOCK_SELECT_MAP_VH
`define ADDR_PLL_CONTROL           8'h1c
`define ADDR_PLL_BANDWIDTH_CONTROL 8'h1d
`define ADDR_PLL_PROGRAMMING       8'h1e
`define BIT_LOCK_IE                7
`define BIT_LOCK_FLAG              6
`define BIT_PLL_ENABLE             5
`define BIT_SOURCE_SELECT          4
`define BIT_AUTO_BW                7
`define BIT_LOCK                   6
`define BIT_TRACKING               5
`define BIT_XTAL_LOSS              4
`define CONTROL_LOW_BITS           4'hf
`define BANDWIDTH_LOW_BITS         4'h0
`define PROGRAMMING_RESET          8'h66
`define NIBBLE_ZERO                4'h0
`define SETTLE_CYCLES              2'h3
`define LOSS_WAIT_UNIT             3'h4
`define READ_ZERO                  8'h00
`endif

/* src/pll_clock_select_control.v */
// clock generator control registers, base clock selector and lock status logic
//
// Function
// - lock interrupt enable ignores writes and reads zero while automatic bandwidth is off
// - lock-change flag sets on every lock indicator transition in automatic mode, either direction
// - interrupt request asserted when lock-change flag and enable both set and the oscillator is enabled
// - lock-change flag reads zero when automatic bandwidth is off
// - a read of the control register clears the lock-change flag unless a lock edge arrives in the same cycle
// - reset sets pll enable, clears interrupt enable and lock-change flag
// - pll enable cannot be cleared while the vco drives the base clock
// - source select forced zero while pll off or range select zero
// - base clock held static on switch until three cycles of each clock have passed
// - reset and stop both clear the source select bit
// - base clock is selected source divided by two, 50% duty
// - control register low four bits read as one
// - bandwidth mode bit read/write, one automatic, reset clears
// - lock indicator read-only in automatic mode, zero in manual, reset clears
// - filter mode bit: one tracking, status in automatic, control in manual
// - last written filter mode kept hidden in automatic, restored in manual
// - reset clears filter mode, acquisition first
// - loss-detect: write one, wait four times n cycles, read; one means crystal dead
// - loss-detect bit reads zero while source select is zero
// - programming register read-only while pll enable is one
// - programming upper nibble is multiplier n, zero acts as one, reset six
// - zero range select disables pll and clears source select
//
// The plain strobed port was chosen for this implementation.
`include "pll_clock_select_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pll_clock_select_control
(
	// clock and reset
	input  wire       ref_clk,
	input  wire       arst_n,
	// register port
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	// analog loop and system inputs, asynchronous
	input  wire       crystal_clock,
	input  wire       vco_clock,
	input  wire       lock_detect,
	input  wire       tracking_detect,
	input  wire       oscillator_enable_in,
	input  wire       stop_request,
	// outputs
	output reg        base_clock_out,
	output reg        lock_interrupt_request,
	output reg        pll_enable_out,
	output reg  [3:0] feedback_multiplier,
	output reg  [3:0] vco_range_select
);

	// synchroniser stages
	reg [1:0] sync_xclk;
	reg [1:0] sync_vclk;
	reg [1:0] sync_lock;
	reg [1:0] sync_trk;
	reg [1:0] sync_osc;
	reg [1:0] sync_stop;
	// edge history of synced clocks, stop request and lock bit
	reg       xclk_prev;
	reg       vclk_prev;
	reg       lock_prev;
	reg       stop_prev;
	// register state
	reg       lock_interrupt_enable;
	reg       lock_change_flag;
	reg       pll_enable;
	reg       clock_source_select;
	reg       auto_bw;
	reg       lock_bit;
	reg       filter_hold;
	reg       loss_armed;
	reg       loss_seen;
	reg [7:0] pll_programming;
	// selector state
	reg       active_src;
	reg       switching;
	reg [1:0] x_count;
	reg [1:0] v_count;
	reg [5:0] loss_count;

	wire xclk_rise = sync_xclk[1] & ~xclk_prev;
	wire vclk_rise = sync_vclk[1] & ~vclk_prev;
	wire stop_rise = sync_stop[1] & ~stop_prev;
	wire wr_ctl = wr & (addr == `ADDR_PLL_CONTROL);
	wire wr_bw  = wr & (addr == `ADDR_PLL_BANDWIDTH_CONTROL);
	wire wr_ppg = wr & (addr == `ADDR_PLL_PROGRAMMING);
	wire rd_ctl = rd & (addr == `ADDR_PLL_CONTROL);
	wire range_zero = (pll_programming[3:0] == `NIBBLE_ZERO);
	// filter mode seen by software: live status in automatic, held value in manual
	wire filter_read = auto_bw ? sync_trk[1] : filter_hold;
	// loss window of four times n vco cycles, zero n acts as one
	wire [3:0] n_eff = (pll_programming[7:4] == `NIBBLE_ZERO) ? 4'h1 : pll_programming[7:4];
	wire [5:0] loss_limit = {n_eff, 2'b00};

	// two-flop synchronisers for everything from outside this clock
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_xclk <= 2'b00;
			sync_vclk <= 2'b00;
			sync_lock <= 2'b00;
			sync_trk  <= 2'b00;
			sync_osc  <= 2'b00;
			sync_stop <= 2'b00;
			xclk_prev <= 1'b0;
			vclk_prev <= 1'b0;
			stop_prev <= 1'b0;
		end
		else
		begin
			sync_xclk <= {sync_xclk[0], crystal_clock};
			sync_vclk <= {sync_vclk[0], vco_clock};
			sync_lock <= {sync_lock[0], lock_detect};
			sync_trk  <= {sync_trk[0], tracking_detect};
			sync_osc  <= {sync_osc[0], oscillator_enable_in};
			sync_stop <= {sync_stop[0], stop_request};
			xclk_prev <= sync_xclk[1];
			vclk_prev <= sync_vclk[1];
			stop_prev <= sync_stop[1];
		end
	end

	// control register
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lock_interrupt_enable <= 1'b0;
			lock_change_flag      <= 1'b0;
			pll_enable            <= 1'b1;
			clock_source_select   <= 1'b0;
		end
		else
		begin
			if (wr_ctl && auto_bw)
				lock_interrupt_enable <= wdata[`BIT_LOCK_IE];
			else if (!auto_bw)
				lock_interrupt_enable <= 1'b0;
			// a lock edge in the clearing cycle still sets the flag
			if (auto_bw && (lock_bit != lock_prev))
				lock_change_flag <= 1'b1;
			else if (rd_ctl || !auto_bw)
				lock_change_flag <= 1'b0;
			// enable and select can change in the same write; each judged on old state
			if (wr_ctl && !clock_source_select)
				pll_enable <= wdata[`BIT_PLL_ENABLE];
			else if (range_zero && !clock_source_select)
				pll_enable <= 1'b0;
			if (stop_rise || !pll_enable || range_zero)
				clock_source_select <= 1'b0;
			else if (wr_ctl)
				clock_source_select <= wdata[`BIT_SOURCE_SELECT];
		end
	end

	// bandwidth register and lock tracking
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			auto_bw     <= 1'b0;
			lock_bit    <= 1'b0;
			lock_prev   <= 1'b0;
			filter_hold <= 1'b0;
			loss_armed  <= 1'b0;
			loss_seen   <= 1'b0;
			loss_count  <= 6'h00;
		end
		else
		begin
			if (wr_bw)
				auto_bw <= wdata[`BIT_AUTO_BW];
			lock_bit  <= auto_bw & sync_lock[1];
			lock_prev <= lock_bit;
			// hidden copy follows writes in either mode, shown again in manual
			if (wr_bw)
				filter_hold <= wdata[`BIT_TRACKING];
			// loss window counts vco edges; no crystal edge seen means crystal dead
			if (wr_bw && wdata[`BIT_XTAL_LOSS])
			begin
				loss_armed <= 1'b1;
				loss_seen  <= 1'b0;
				loss_count <= 6'h00;
			end
			else if (loss_armed)
			begin
				if (xclk_rise)
					loss_seen <= 1'b1;
				if (vclk_rise)
					loss_count <= loss_count + 6'h01;
				if (vclk_rise && (loss_count + 6'h01 >= loss_limit))
					loss_armed <= 1'b0;
			end
		end
	end

	// programming register, frozen while the loop runs
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			pll_programming <= `PROGRAMMING_RESET;
		else if (wr_ppg && !pll_enable)
			pll_programming <= wdata;
	end

	// transition control and divide-by-two output
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			active_src     <= 1'b0;
			switching      <= 1'b0;
			x_count        <= 2'h0;
			v_count        <= 2'h0;
			base_clock_out <= 1'b0;
		end
		else if (!sync_osc[1])
		begin
			// oscillator disable holds the output low
			base_clock_out <= 1'b0;
			active_src     <= 1'b0;
			switching      <= 1'b0;
		end
		else if (switching)
		begin
			// output held in stasis until both clocks have ticked enough
			if (xclk_rise && x_count != `SETTLE_CYCLES)
				x_count <= x_count + 2'h1;
			if (vclk_rise && v_count != `SETTLE_CYCLES)
				v_count <= v_count + 2'h1;
			if (x_count == `SETTLE_CYCLES && v_count == `SETTLE_CYCLES)
			begin
				switching  <= 1'b0;
				active_src <= clock_source_select;
			end
		end
		else if (active_src != clock_source_select)
		begin
			switching <= 1'b1;
			x_count   <= 2'h0;
			v_count   <= 2'h0;
		end
		else if (active_src ? vclk_rise : xclk_rise)
			base_clock_out <= ~base_clock_out;
	end

	// read data one cycle after the strobe, plus mirrored outputs
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata                  <= `READ_ZERO;
			lock_interrupt_request <= 1'b0;
			pll_enable_out         <= 1'b1;
			feedback_multiplier    <= 4'h6;
			vco_range_select       <= 4'h6;
		end
		else
		begin
			lock_interrupt_request <= sync_osc[1] & lock_change_flag & lock_interrupt_enable;
			pll_enable_out         <= pll_enable & ~range_zero;
			feedback_multiplier    <= n_eff;
			vco_range_select       <= pll_programming[3:0];
			if (!rd)
				rdata <= `READ_ZERO;
			else if (addr == `ADDR_PLL_CONTROL)
				rdata <= {lock_interrupt_enable & auto_bw, lock_change_flag & auto_bw,
					pll_enable, clock_source_select, `CONTROL_LOW_BITS};
			else if (addr == `ADDR_PLL_BANDWIDTH_CONTROL)
				rdata <= {auto_bw, lock_bit, filter_read,
					loss_seen ? 1'b0 : clock_source_select & ~loss_armed, `BANDWIDTH_LOW_BITS};
			else if (addr == `ADDR_PLL_PROGRAMMING)
				rdata <= pll_programming;
			else
				rdata <= `READ_ZERO;
		end
	end

endmodule
`default_nettype wire

/* test/pll_analog_model.sv */
// crystal oscillator and vco stand-in for the clock select block
`timescale 1ns/1ps
`default_nettype none
module pll_analog_model
#(
	parameter XTAL_HALF = 100,
	parameter VCO_HALF  = 60
)
(
	// crystal control from the bench
	input  wire logic crystal_run,
	// analog clock outputs
	output logic      crystal_clock,
	output logic      vco_clock
);
	initial {crystal_clock, vco_clock} = 2'b00;
	// vco free runs from time zero, whatever the loop does
	always #VCO_HALF vco_clock = ~vco_clock;
	// a dead crystal stands still, which is what loss detection looks for
	always #XTAL_HALF if (crystal_run) crystal_clock = ~crystal_clock;
endmodule
`default_nettype wire

/* test/pll_clock_select_checker.sv */
// port assertions for the clock select block
`timescale 1ns/1ps
`default_nettype none
module pll_clock_select_checker
(
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       arst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// outputs
	input wire logic       lock_interrupt_request,
	input wire logic       pll_enable_out,
	input wire logic [3:0] feedback_multiplier,
	input wire logic [3:0] vco_range_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	reg auto_on;
	// shadow of the bandwidth mode, so checks need not peek inside
	always @(posedge ref_clk or negedge arst_n)
		if (!arst_n) auto_on <= 1'b0;
		else if (wr && addr == 8'h1d) auto_on <= wdata[7];
	a_ctrl_low_ones:
		assert property (rd && addr == 8'h1c |=> rdata[3:0] == 4'hf) else $error("control low bits not ones");
	a_bw_low_zero:
		assert property (rd && addr == 8'h1d |=> rdata[3:0] == 4'h0) else $error("bandwidth low bits not zero");
	a_prog_locked:
		assert property (wr && addr == 8'h1e && pll_enable_out |=> $stable(feedback_multiplier)
			&& $stable(vco_range_select)) else $error("programming written while pll on");
	a_irq_read_clear:
		assert property (rd && addr == 8'h1c && lock_interrupt_request |-> ##[1:3] !lock_interrupt_request)
			else $error("interrupt not cleared by read");
	a_mult_nonzero:
		assert property (feedback_multiplier != 4'h0) else $error("multiplier shows zero");
	a_range_zero_off:
		assert property (vco_range_select == 4'h0 |-> !pll_enable_out) else $error("pll on with zero range");
	a_manual_ctrl_zero:
		assert property (rd && addr == 8'h1c && !auto_on |=> rdata[7:6] == 2'b00) else $error("enable or flag seen");
	a_manual_lock_zero:
		assert property (rd && addr == 8'h1d && !auto_on |=> !rdata[6]) else $error("lock seen in manual mode");
endmodule
bind pll_clock_select_control pll_clock_select_checker i_checker (.*);
`default_nettype wire

/* test/pll_clock_select_control_test.sv */
// self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none
module pll_clock_select_control_test;
	logic       ref_clk, arst_n, wr, rd, lock_detect, tracking_detect, stop_request, crystal_run;
	logic       oscillator_enable_in = 1'b1;
	logic [7:0] addr, wdata;
	wire  [7:0] rdata;
	wire        crystal_clock, vco_clock, base_clock_out, lock_interrupt_request, pll_enable_out;
	wire  [3:0] feedback_multiplier, vco_range_select;
	int         fail_count = 0;
	int         compares = 0;
	time        t0, t1, t2;
	logic       b0;
	logic       held = 1'b1;
	pll_clock_select_control i_dut (.*);
	pll_analog_model i_model (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input string nm, input logic [7:0] e, g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr_reg(input logic [7:0] a, d);
		@(posedge ref_clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, e, input logic [7:0] m = 8'hff);
		@(posedge ref_clk);
		addr <= a; rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata & m);
	endtask
	// p is the source period; sync jitter allows one ref cycle per edge
	task per_chk(input int p);
		@(posedge base_clock_out) t0 = $time;
		@(negedge base_clock_out) t1 = $time;
		@(posedge base_clock_out) t2 = $time;
		chk("base period", 8'h01, {7'h0, t2 - t0 >= 2 * p - 20 && t2 - t0 <= 2 * p + 20});
		chk("base high", 8'h01, {7'h0, t1 - t0 >= p - 20 && t1 - t0 <= p + 20});
	endtask
	task t_reset;
		rd_chk(8'h1c, 8'h2f);
		rd_chk(8'h1d, 8'h00);
		rd_chk(8'h1e, 8'h66);
		rd_chk(8'h1f, 8'h00);
		chk("pll_enable_out", 8'h01, {7'h0, pll_enable_out});
		per_chk(200);
	endtask
	task t_program;
		wr_reg(8'h1e, 8'h0a);
		rd_chk(8'h1e, 8'h66);
		wr_reg(8'h1c, 8'h00);
		wr_reg(8'h1e, 8'h0a);
		rd_chk(8'h1e, 8'h0a);
		chk("feedback_multiplier", 8'h01, {4'h0, feedback_multiplier});
		chk("vco_range_select", 8'h0a, {4'h0, vco_range_select});
		wr_reg(8'h1e, 8'h30);
		wr_reg(8'h1c, 8'h30);
		rd_chk(8'h1c, 8'h00, 8'h10);
		chk("pll_enable_out", 8'h00, {7'h0, pll_enable_out});
		wr_reg(8'h1c, 8'h00);
		wr_reg(8'h1e, 8'h66);
	endtask
	task t_select;
		wr_reg(8'h1c, 8'h90);
		rd_chk(8'h1c, 8'h0f);
		wr_reg(8'h1c, 8'h20);
		wr_reg(8'h1c, 8'h30);
		rd_chk(8'h1c, 8'h3f);
		// three crystal edges take longer than 30 cycles, so the output must stand still
		b0 = base_clock_out;
		repeat (30) @(posedge ref_clk) if (base_clock_out !== b0) held = 1'b0;
		chk("base held", 8'h01, {7'h0, held});
		wr_reg(8'h1c, 8'h10);
		rd_chk(8'h1c, 8'h3f);
		per_chk(120);
	endtask
	// 4 x 6 vco cycles of 120 ns fit well inside 400 ref cycles
	task t_loss;
		crystal_run <= 1'b0;
		// let a crystal edge already in the synchroniser drain before arming
		repeat (4) @(posedge ref_clk);
		wr_reg(8'h1d, 8'h10);
		repeat (400) @(posedge ref_clk);
		rd_chk(8'h1d, 8'h10, 8'h10);
		crystal_run <= 1'b1;
		wr_reg(8'h1d, 8'h10);
		repeat (400) @(posedge ref_clk);
		rd_chk(8'h1d, 8'h00, 8'h10);
		stop_request <= 1'b1;
		repeat (5) @(posedge ref_clk);
		stop_request <= 1'b0;
		rd_chk(8'h1c, 8'h2f);
		rd_chk(8'h1d, 8'h00, 8'h10);
		@(posedge ref_clk);
		oscillator_enable_in <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk("base_clock_out", 8'h00, {7'h0, base_clock_out});
		oscillator_enable_in <= 1'b1;
	endtask
	task t_auto;
		wr_reg(8'h1d, 8'h20);
		rd_chk(8'h1d, 8'h20);
		wr_reg(8'h1d, 8'ha0);
		rd_chk(8'h1d, 8'h80);
		wr_reg(8'h1c, 8'ha0);
		rd_chk(8'h1c, 8'haf);
		lock_detect <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("irq", 8'h01, {7'h0, lock_interrupt_request});
		rd_chk(8'h1d, 8'hc0, 8'hc0);
		rd_chk(8'h1c, 8'hef);
		rd_chk(8'h1c, 8'haf);
		chk("irq", 8'h00, {7'h0, lock_interrupt_request});
		lock_detect <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk("irq", 8'h01, {7'h0, lock_interrupt_request});
		wr_reg(8'h1d, 8'h20);
		rd_chk(8'h1c, 8'h2f);
		rd_chk(8'h1d, 8'h20);
	endtask
	task finish_test;
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{wr, rd, addr, wdata, lock_detect, tracking_detect, stop_request} = '0;
		crystal_run = 1'b1;
		arst_n = 1'b0;
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset;
		t_program;
		t_select;
		t_loss;
		t_auto;
		finish_test;
	end
	// whole run is about 11 us; nine times that means a hang
	initial
	begin
		#100000;
		fail_count++;
		finish_test;
	end
endmodule
`default_nettype wire
